// ---- pss_pkg.sv ----
// Constants shared by the sequencing and status bank and its helpers.
// Assumes a 10 MHz system clock; command codes are PMBus codes.
package pss_pkg;

  // Clock and the millisecond base of every timing register
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int MILLISECOND_NS = 1000000;
  localparam int MS_CYCLES = MILLISECOND_NS / CLOCK_PERIOD_NS;

  // Command codes
  localparam logic [7:0] CMD_TURN_ON_DELAY = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RISE_TIME = 8'h61;
  localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
  localparam logic [7:0] CMD_TURN_OFF_FALL_TIME = 8'h65;
  localparam logic [7:0] CMD_FAULT_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_FAULT_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FLAGS = 8'h7a;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_FLAGS = 8'h7b;
  localparam logic [7:0] CMD_INPUT_SUPPLY_FLAGS = 8'h7c;

  // Timer slots; ranges in ms, slot 0 is the last element
  localparam int TIMER_ON_DELAY = 0;
  localparam int TIMER_ON_RISE = 1;
  localparam int TIMER_OFF_DELAY = 2;
  localparam int TIMER_OFF_FALL = 3;
  localparam logic [3:0][15:0] TIMER_MIN_MS =
    {16'h0000, 16'h0000, 16'h0000, 16'h0002};
  localparam logic [3:0][15:0] TIMER_MAX_MS =
    {16'h0064, 16'h0100, 16'h0064, 16'h0100};

  // Reset values of the status storage
  localparam logic [7:0] SUMMARY_RESET = 8'h00;
  localparam logic [3:0] DETAIL_RESET = 4'h0;
  localparam logic [3:0] DETAIL_UNUSED = 4'h0;

  // Summary byte (also the status word low byte)
  localparam int SB_BUSY = 7;
  localparam int SB_OFF = 6;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_IOUT_OC = 4;
  localparam int SB_VIN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SB_NONE_ABOVE = 0;

  // Status word high byte, bit 15 is position 7
  localparam int HB_VOUT = 7;
  localparam int HB_IOUT = 6;
  localparam int HB_INPUT = 5;
  localparam int HB_MFR = 4;
  localparam int HB_PG_N = 3;
  localparam int HB_FANS = 2;
  localparam int HB_OTHER = 1;
  localparam int HB_UNKNOWN = 0;

  // Detail nibbles, reported in bits 7:4 of their register
  localparam int DT_HIGH_FAULT = 3;
  localparam int DT_HIGH_WARN = 2;
  localparam int DT_LOW_WARN = 1;
  localparam int DT_LOW_FAULT = 0;

  typedef enum logic [2:0] {
    SEQ_OFF,
    SEQ_ON_DELAY,
    SEQ_RISING,
    SEQ_ON,
    SEQ_OFF_DELAY,
    SEQ_FALLING
  } pss_seq_state_type;

endpackage

// ---- pss_ms_tick.sv ----
// Millisecond enable divider for the sequencing timers.
// Assumes CYCLES of at least 2; restart realigns the tick phase.
module pss_ms_tick #(
  parameter int CYCLES = pss_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Control and enable out
  input wire logic restart,
  output logic tick
);

  localparam int W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] count;
    logic tick;
  } pss_tick_state_type;

  pss_tick_state_type st;
  pss_tick_state_type next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (restart) begin
      next_st.count = '0;
    end else if (st.count == W'(CYCLES - 1)) begin
      next_st.count = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = W'(st.count + 1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

// ---- pss_l11_ms.sv ----
// Converts an L11 register value to whole milliseconds, clamped.
// Fractions are truncated; negative values take the minimum.
module pss_l11_ms #(
  parameter logic [15:0] MIN_MS = 16'h0000,
  parameter logic [15:0] MAX_MS = 16'h0100
) (
  // Raw register and converted time
  input wire logic [15:0] l11,
  output logic [15:0] ms
);

  always_comb begin
    logic [31:0] mag;
    logic [4:0] right;
    mag = 32'h0;
    right = 5'(~l11[15:11] + 5'h01);
    // Exponent 0..15 cannot overflow 32 bits with an 11-bit mantissa
    if (!l11[15]) begin
      mag = {21'h0, l11[10:0]} << l11[14:11];
    end else begin
      mag = {21'h0, l11[10:0]} >> right;
    end
    if (l11[10] || mag < {16'h0, MIN_MS}) begin
      ms = MIN_MS;
    end else if (mag > {16'h0, MAX_MS}) begin
      ms = MAX_MS;
    end else begin
      ms = mag[15:0];
    end
  end

endmodule

// ---- pss_seq_status.sv ----
// Soft-start/stop sequencer, power-good and status registers.
// Assumes a PMBus transaction layer on the same clock drives the
// command port, and fault detectors on the same clock drive the sets.
//
// Function
// R01: After enable, wait turn-on delay (2 to 256 ms) before ramping up.
// R02: After turn-on delay, ramp output up over rise time (0 to 100 ms).
// R03: On disable, wait turn-off delay (0 to 256 ms) before falling.
// R04: After turn-off delay, ramp down over fall time (0 to 100 ms).
// R05: Power-good asserts a delay after threshold, drops below UV warning.
// R06: Summary bit 7 set on a busy fault.
// R07: Summary bit 6 set whenever the output is not powered.
// R08: Summary bits 5, 4, 3: output OV, output OC, input UV faults.
// R09: Summary bit 2 on temperature events, bit 1 on CML faults.
// R10: Summary bit 0 on any event not covered by bits 7 to 1.
// R11: Status word low byte is the summary byte storage itself.
// R12: Word bits 15, 14, 13: output voltage, current/power, input events.
// R13: Word bit 12 on maker-specific events, bit 11 while not power-good.
// R14: Word bit 10 fans, bit 9 other status, bit 8 unknown faults.
// R15: Output voltage detail: OV fault, OV warn, UV warn, UV fault, 7:4.
// R16: Output current detail: OC, OC low-volt, OC warn, UC fault, 7:4.
// R17: Status registers read-only, reset to zero.
// R18: Host uses word summary bits to choose detail registers to read.
// R19: Input detail: OV fault, OV warn, UV warn, UV fault in bits 7:4.
// R20: Each summary bit is the OR of its detail bits.
module pss_seq_status #(
  parameter int MS_CYCLES = pss_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Asynchronous pins and comparators
  input wire logic enable_pin,
  input wire logic vout_above_pg_on,
  input wire logic vout_below_uv_warn,
  // Strap values loaded at reset, and the power-good delay
  input wire logic [15:0] strap_turn_on_delay,
  input wire logic [15:0] strap_turn_on_rise_time,
  input wire logic [15:0] strap_turn_off_delay,
  input wire logic [15:0] strap_turn_off_fall_time,
  input wire logic [15:0] pg_delay_ms,
  // Command port
  input wire logic [7:0] cmd_code,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_wdata,
  output logic resp_valid,
  output logic resp_refused,
  output logic [15:0] resp_rdata,
  // Fault and warning detectors
  input wire logic [3:0] vout_flag_set,
  input wire logic [3:0] iout_flag_set,
  input wire logic [3:0] vin_flag_set,
  input wire logic temp_event,
  input wire logic cml_event,
  input wire logic mfr_event,
  input wire logic fan_event,
  input wire logic other_event,
  input wire logic busy_event,
  input wire logic unknown_event,
  input wire logic clear_faults,
  // Power stage
  output logic power_stage_on,
  output logic soft_start,
  output logic soft_stop,
  output logic power_good
);

  typedef struct packed {
    pss_pkg::pss_seq_state_type seq;
    logic [15:0] elapsed;
    logic [3:0][15:0] timer;
    logic [1:0] en_sync;
    logic [1:0] pg_on_sync;
    logic [1:0] uv_sync;
    logic [15:0] pg_elapsed;
    logic power_good;
    logic [3:0] vout;
    logic [3:0] iout;
    logic [3:0] vin;
    logic temp;
    logic cml;
    logic mfr;
    logic fan;
    logic other;
    logic busy;
    logic unknown;
    logic [7:0] summary_byte;
    logic [7:0] summary_high;
    logic resp_valid;
    logic resp_refused;
    logic [15:0] resp_rdata;
  } pss_bank_state_type;

  pss_bank_state_type st;
  pss_bank_state_type next_st;
  logic [15:0] timer_ms [4];
  logic seq_tick;
  logic pg_tick;
  logic seq_restart;
  logic pg_restart;
  logic seq_done;
  logic enable;
  logic pg_on;
  logic uv;
  logic powered;
  logic status_code;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_conv
      pss_l11_ms #(
        .MIN_MS(pss_pkg::TIMER_MIN_MS[gi]),
        .MAX_MS(pss_pkg::TIMER_MAX_MS[gi])
      ) u_conv (
        .l11(st.timer[gi]),
        .ms(timer_ms[gi])
      );
    end
  endgenerate

  // Tick restarts on each state change so every counted ms is whole
  pss_ms_tick #(.CYCLES(MS_CYCLES)) u_seq_tick (
    .clock(clock),
    .srst(srst),
    .restart(seq_restart),
    .tick(seq_tick)
  );

  pss_ms_tick #(.CYCLES(MS_CYCLES)) u_pg_tick (
    .clock(clock),
    .srst(srst),
    .restart(pg_restart),
    .tick(pg_tick)
  );

  assign enable = st.en_sync[1];
  assign pg_on = st.pg_on_sync[1];
  assign uv = st.uv_sync[1];
  assign status_code = (cmd_code >= pss_pkg::CMD_FAULT_SUMMARY_BYTE) &&
                       (cmd_code <= pss_pkg::CMD_INPUT_SUPPLY_FLAGS);

  always_comb begin
    logic [15:0] target;
    target = 16'h0000;
    case (st.seq)
      pss_pkg::SEQ_ON_DELAY: target = timer_ms[pss_pkg::TIMER_ON_DELAY];
      pss_pkg::SEQ_RISING: target = timer_ms[pss_pkg::TIMER_ON_RISE];
      pss_pkg::SEQ_OFF_DELAY: target = timer_ms[pss_pkg::TIMER_OFF_DELAY];
      pss_pkg::SEQ_FALLING: target = timer_ms[pss_pkg::TIMER_OFF_FALL];
      default: target = 16'h0000;
    endcase
    seq_done = st.elapsed >= target;
  end

  always_comb begin
    next_st = st;
    next_st.en_sync = {st.en_sync[0], enable_pin};
    next_st.pg_on_sync = {st.pg_on_sync[0], vout_above_pg_on};
    next_st.uv_sync = {st.uv_sync[0], vout_below_uv_warn};
    next_st.resp_valid = 1'b0;
    next_st.resp_refused = 1'b0;

    // Sequencer
    case (st.seq)
      pss_pkg::SEQ_OFF: begin
        if (enable) next_st.seq = pss_pkg::SEQ_ON_DELAY; // see R01
      end
      pss_pkg::SEQ_ON_DELAY: begin
        if (!enable) next_st.seq = pss_pkg::SEQ_OFF;
        else if (seq_done) next_st.seq = pss_pkg::SEQ_RISING; // see R01
      end
      pss_pkg::SEQ_RISING: begin
        if (!enable) next_st.seq = pss_pkg::SEQ_OFF_DELAY;
        else if (seq_done) next_st.seq = pss_pkg::SEQ_ON; // see R02
      end
      pss_pkg::SEQ_ON: begin
        if (!enable) next_st.seq = pss_pkg::SEQ_OFF_DELAY; // see R03
      end
      pss_pkg::SEQ_OFF_DELAY: begin
        // Re-enable before the fall starts keeps the output up
        if (enable) next_st.seq = pss_pkg::SEQ_ON;
        else if (seq_done) next_st.seq = pss_pkg::SEQ_FALLING; // see R03
      end
      pss_pkg::SEQ_FALLING: begin
        if (seq_done) next_st.seq = pss_pkg::SEQ_OFF; // see R04
      end
      default: next_st.seq = pss_pkg::SEQ_OFF;
    endcase
    seq_restart = next_st.seq != st.seq;
    if (seq_restart) begin
      next_st.elapsed = 16'h0000;
    end else if (seq_tick && st.elapsed != 16'hffff) begin
      next_st.elapsed = 16'(st.elapsed + 16'h0001);
    end
    powered = next_st.seq != pss_pkg::SEQ_OFF &&
              next_st.seq != pss_pkg::SEQ_ON_DELAY;

    // Power-good with hysteresis between threshold and UV warning
    pg_restart = !pg_on || st.power_good;
    if (uv) begin
      next_st.power_good = 1'b0; // see R05
      next_st.pg_elapsed = 16'h0000;
    end else if (!st.power_good) begin
      if (!pg_on) begin
        next_st.pg_elapsed = 16'h0000;
      end else if (st.pg_elapsed >= pg_delay_ms) begin
        next_st.power_good = 1'b1; // see R05
      end else if (pg_tick) begin
        next_st.pg_elapsed = 16'(st.pg_elapsed + 16'h0001);
      end
    end

    // Sticky detail flags; a set in the clear cycle wins
    if (clear_faults) begin
      next_st.vout = pss_pkg::DETAIL_RESET;
      next_st.iout = pss_pkg::DETAIL_RESET;
      next_st.vin = pss_pkg::DETAIL_RESET;
      {next_st.temp, next_st.cml, next_st.mfr, next_st.fan} = 4'h0;
      {next_st.other, next_st.busy, next_st.unknown} = 3'h0;
    end
    next_st.vout = next_st.vout | vout_flag_set; // see R15
    next_st.iout = next_st.iout | iout_flag_set; // see R16
    next_st.vin = next_st.vin | vin_flag_set; // see R19
    next_st.temp = next_st.temp | temp_event;
    next_st.cml = next_st.cml | cml_event;
    next_st.mfr = next_st.mfr | mfr_event;
    next_st.fan = next_st.fan | fan_event;
    next_st.other = next_st.other | other_event;
    next_st.busy = next_st.busy | busy_event;
    next_st.unknown = next_st.unknown | unknown_event;

    // Summaries follow the details in the same cycle
    next_st.summary_byte[pss_pkg::SB_BUSY] = next_st.busy; // see R06
    next_st.summary_byte[pss_pkg::SB_OFF] = !powered; // see R07
    next_st.summary_byte[pss_pkg::SB_VOUT_OV] =
      next_st.vout[pss_pkg::DT_HIGH_FAULT]; // see R08
    next_st.summary_byte[pss_pkg::SB_IOUT_OC] =
      next_st.iout[pss_pkg::DT_HIGH_FAULT]; // see R08
    next_st.summary_byte[pss_pkg::SB_VIN_UV] =
      next_st.vin[pss_pkg::DT_LOW_FAULT]; // see R08
    next_st.summary_byte[pss_pkg::SB_TEMP] = next_st.temp; // see R09
    next_st.summary_byte[pss_pkg::SB_CML] = next_st.cml; // see R09
    next_st.summary_byte[pss_pkg::SB_NONE_ABOVE] = // see R10
      (|next_st.vout[2:0]) | (|next_st.iout[2:0]) |
      (|next_st.vin[3:1]) | next_st.mfr | next_st.fan |
      next_st.other | next_st.unknown;
    next_st.summary_high[pss_pkg::HB_VOUT] = |next_st.vout; // see R12 R20
    next_st.summary_high[pss_pkg::HB_IOUT] = |next_st.iout; // see R12 R20
    next_st.summary_high[pss_pkg::HB_INPUT] = |next_st.vin; // see R12 R20
    next_st.summary_high[pss_pkg::HB_MFR] = next_st.mfr; // see R13
    next_st.summary_high[pss_pkg::HB_PG_N] = !next_st.power_good; // see R13
    next_st.summary_high[pss_pkg::HB_FANS] = next_st.fan; // see R14
    next_st.summary_high[pss_pkg::HB_OTHER] = next_st.other; // see R14
    next_st.summary_high[pss_pkg::HB_UNKNOWN] = next_st.unknown; // see R14

    // Command port; a read wins over a write in the same cycle
    if (cmd_read) begin
      next_st.resp_valid = 1'b1;
      next_st.resp_rdata = 16'h0000;
      if (cmd_code == pss_pkg::CMD_TURN_ON_DELAY) begin
        next_st.resp_rdata = st.timer[pss_pkg::TIMER_ON_DELAY];
      end else if (cmd_code == pss_pkg::CMD_TURN_ON_RISE_TIME) begin
        next_st.resp_rdata = st.timer[pss_pkg::TIMER_ON_RISE];
      end else if (cmd_code == pss_pkg::CMD_TURN_OFF_DELAY) begin
        next_st.resp_rdata = st.timer[pss_pkg::TIMER_OFF_DELAY];
      end else if (cmd_code == pss_pkg::CMD_TURN_OFF_FALL_TIME) begin
        next_st.resp_rdata = st.timer[pss_pkg::TIMER_OFF_FALL];
      end else if (cmd_code == pss_pkg::CMD_FAULT_SUMMARY_BYTE) begin
        next_st.resp_rdata = {8'h00, st.summary_byte};
      end else if (cmd_code == pss_pkg::CMD_FAULT_SUMMARY_WORD) begin
        next_st.resp_rdata = {st.summary_high, st.summary_byte}; // see R11
      end else if (cmd_code == pss_pkg::CMD_OUTPUT_VOLTAGE_FLAGS) begin
        next_st.resp_rdata = {8'h00, st.vout, pss_pkg::DETAIL_UNUSED};
      end else if (cmd_code == pss_pkg::CMD_OUTPUT_CURRENT_FLAGS) begin
        next_st.resp_rdata = {8'h00, st.iout, pss_pkg::DETAIL_UNUSED};
      end else if (cmd_code == pss_pkg::CMD_INPUT_SUPPLY_FLAGS) begin
        next_st.resp_rdata = {8'h00, st.vin, pss_pkg::DETAIL_UNUSED};
      end else begin
        next_st.resp_refused = 1'b1;
      end
    end else if (cmd_write) begin
      next_st.resp_valid = 1'b1;
      if (cmd_code == pss_pkg::CMD_TURN_ON_DELAY) begin
        next_st.timer[pss_pkg::TIMER_ON_DELAY] = cmd_wdata;
      end else if (cmd_code == pss_pkg::CMD_TURN_ON_RISE_TIME) begin
        next_st.timer[pss_pkg::TIMER_ON_RISE] = cmd_wdata;
      end else if (cmd_code == pss_pkg::CMD_TURN_OFF_DELAY) begin
        next_st.timer[pss_pkg::TIMER_OFF_DELAY] = cmd_wdata;
      end else if (cmd_code == pss_pkg::CMD_TURN_OFF_FALL_TIME) begin
        next_st.timer[pss_pkg::TIMER_OFF_FALL] = cmd_wdata;
      end else begin
        next_st.resp_refused = 1'b1; // see R17
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0; // see R17
      st.seq <= pss_pkg::SEQ_OFF;
      st.summary_byte <= pss_pkg::SUMMARY_RESET;
      st.summary_high <= pss_pkg::SUMMARY_RESET;
      // Straps are sampled while reset is held
      st.timer[pss_pkg::TIMER_ON_DELAY] <= strap_turn_on_delay;
      st.timer[pss_pkg::TIMER_ON_RISE] <= strap_turn_on_rise_time;
      st.timer[pss_pkg::TIMER_OFF_DELAY] <= strap_turn_off_delay;
      st.timer[pss_pkg::TIMER_OFF_FALL] <= strap_turn_off_fall_time;
    end else begin
      st <= next_st;
    end
  end

  assign resp_valid = st.resp_valid;
  assign resp_refused = st.resp_refused;
  assign resp_rdata = st.resp_rdata;
  assign power_stage_on = st.seq != pss_pkg::SEQ_OFF &&
                          st.seq != pss_pkg::SEQ_ON_DELAY;
  assign soft_start = st.seq == pss_pkg::SEQ_RISING;
  assign soft_stop = st.seq == pss_pkg::SEQ_FALLING;
  assign power_good = st.power_good;

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_on_delay_exit;
    st.seq == pss_pkg::SEQ_ON_DELAY ##1 st.seq == pss_pkg::SEQ_RISING;
  endsequence

  sequence s_off_delay_exit;
    st.seq == pss_pkg::SEQ_OFF_DELAY ##1 st.seq == pss_pkg::SEQ_FALLING;
  endsequence

  AST_START_WAITS: assert property ( // see R01
    (st.seq == pss_pkg::SEQ_OFF && enable) |=>
    st.seq == pss_pkg::SEQ_ON_DELAY && st.elapsed == 16'h0000)
    else $error("enable did not start the turn-on delay");
  AST_ON_DELAY_SPENT: assert property ( // see R01
    s_on_delay_exit |-> $past(seq_done) && $past(enable))
    else $error("ramp began before turn-on delay elapsed");
  AST_RISE_ENDS: assert property ( // see R02
    (st.seq == pss_pkg::SEQ_RISING && enable && seq_done) |=>
    st.seq == pss_pkg::SEQ_ON)
    else $error("rise did not end after rise time");
  AST_DISABLE_WAITS: assert property ( // see R03
    (st.seq == pss_pkg::SEQ_ON && !enable) |=>
    st.seq == pss_pkg::SEQ_OFF_DELAY ##1 power_stage_on)
    else $error("disable did not hold output through turn-off delay");
  AST_OFF_DELAY_SPENT: assert property ( // see R03 R04
    s_off_delay_exit |-> $past(seq_done) && !$past(enable))
    else $error("fall began before turn-off delay elapsed");
  AST_PG_DROPS: assert property ( // see R05
    uv |=> !st.power_good && st.summary_high[pss_pkg::HB_PG_N])
    else $error("power-good held below UV warning");
  AST_OFF_BIT: assert property ( // see R07
    (st.seq == pss_pkg::SEQ_OFF ##1 st.seq == pss_pkg::SEQ_OFF) |->
    st.summary_byte[pss_pkg::SB_OFF])
    else $error("off bit clear while output unpowered");
  AST_SET_WINS: assert property ( // see R06 R20
    (clear_faults && busy_event && vout_flag_set[pss_pkg::DT_HIGH_FAULT])
    |=> st.summary_byte[pss_pkg::SB_BUSY] &&
    st.summary_byte[pss_pkg::SB_VOUT_OV] && st.summary_high[pss_pkg::HB_VOUT])
    else $error("event lost against a clear");
  AST_SUMMARY_OR: assert property ( // see R12 R20
    st.summary_high[pss_pkg::HB_VOUT] == (|st.vout) &&
    st.summary_high[pss_pkg::HB_INPUT] == (|st.vin) &&
    st.summary_byte[pss_pkg::SB_IOUT_OC] == st.iout[pss_pkg::DT_HIGH_FAULT])
    else $error("summary bit differs from its details");
  AST_WORD_LOW: assert property ( // see R11
    (cmd_read && cmd_code == pss_pkg::CMD_FAULT_SUMMARY_WORD) |=>
    resp_valid && resp_rdata[7:0] == $past(st.summary_byte))
    else $error("word low byte differs from summary byte");
  AST_READ_ONLY: assert property ( // see R17
    (cmd_write && !cmd_read && status_code) |=>
    resp_valid && resp_refused)
    else $error("write to status register not refused");

endmodule

// ---- pss_host_model.sv ----
// Host model that issues requests on the command port of the bank.
// Assumes each request is answered one cycle after it is taken.
module pss_host_model (
  // Clock
  input wire logic clock,
  // Command port
  output logic [7:0] cmd_code,
  output logic cmd_read,
  output logic cmd_write,
  output logic [15:0] cmd_wdata,
  input wire logic resp_valid,
  input wire logic resp_refused,
  input wire logic [15:0] resp_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_code = 8'h00;
    cmd_read = 1'b0;
    cmd_write = 1'b0;
    cmd_wdata = 16'h0000;
  end

  // One-cycle request, then a bounded wait for its answer
  task automatic xfer(input logic rd, input logic [7:0] code,
    input logic [15:0] wd, output logic [15:0] q, output logic r,
    output logic ok);
    int i;
    @(posedge clock);
    #1;
    cmd_code = code;
    cmd_read = rd;
    cmd_write = !rd;
    cmd_wdata = wd;
    ok = 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      @(posedge clock);
      #1;
      cmd_read = 1'b0;
      cmd_write = 1'b0;
      // Released lines show the inverse, so stale values never match
      cmd_code = ~code;
      cmd_wdata = ~wd;
      ok = (resp_valid === 1'b1);
    end
    q = resp_rdata;
    r = resp_refused;
  endtask
endmodule

// ---- pss_seq_status_tb_top.sv ----
// Self-checking bench for the sequencing and status bank.
// Assumes a 10 MHz clock and the host model on the command port.
module pss_seq_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Short millisecond keeps the sequencing waits brief
  localparam int MS = 4;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic enable_pin = 1'b0, above = 1'b0, below = 1'b0, clear = 1'b0;
  logic [7:0] cmd_code;
  logic cmd_read, cmd_write, resp_valid, resp_refused;
  logic [15:0] cmd_wdata, resp_rdata;
  logic [18:0] ev = 19'h00000;
  logic pso, s_start, s_stop, pgood;
  logic [3:0] outs;
  // Non-zero power-good delay so the delay count is really timed
  logic [15:0] pg_dly = 16'h0001;
  int n_errors = 0, checks_done = 0, i, n;
  int ev_bit[15] = '{18, 17, 15, 14, 13, 12, 9, 7, 6, 5, 4, 3, 2, 1, 0};
  logic [15:0] w_exp[15] = '{16'h8860, 16'h8841, 16'h8841, 16'h4850,
    16'h4841, 16'h4841, 16'h2841, 16'h2848, 16'h0844, 16'h0842,
    16'h1841, 16'h0c41, 16'h0a41, 16'h08c0, 16'h0941};
  logic [7:0] d_code[15] = '{8'h7a, 8'h7a, 8'h7a, 8'h7b, 8'h7b, 8'h7b,
    8'h7c, 8'h7c, 8'h7a, 8'h7a, 8'h7a, 8'h7a, 8'h7a, 8'h7a, 8'h7a};
  logic [7:0] d_exp[15] = '{8'h80, 8'h40, 8'h10, 8'h80, 8'h40, 8'h20,
    8'h40, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] ro_exp[5] = '{16'h0040, 16'h0840, 16'h0000, 16'h0000,
    16'h0000};
  logic [7:0] t_code[4] = '{8'h60, 8'h61, 8'h64, 8'h65};
  logic [15:0] t_strap[4] = '{16'h0003, 16'h0004, 16'h0000, 16'h0001};
  // On delay 0 clamps to 2 ms; rise f806h is 6 halved, 3 ms;
  // fall 0801h is 1 ms shifted once, 2 ms
  logic [15:0] t_new[4] = '{16'h0000, 16'hf806, 16'h0001, 16'h0801};

  assign outs = {pgood, s_stop, s_start, pso};
  always #50 clock = ~clock;

  pss_seq_status #(.MS_CYCLES(MS)) pss_seq_status_i (
    .clock(clock), .srst(srst), .enable_pin(enable_pin),
    .vout_above_pg_on(above), .vout_below_uv_warn(below),
    .strap_turn_on_delay(t_strap[0]), .strap_turn_on_rise_time(t_strap[1]),
    .strap_turn_off_delay(t_strap[2]),
    .strap_turn_off_fall_time(t_strap[3]), .pg_delay_ms(pg_dly),
    .cmd_code(cmd_code), .cmd_read(cmd_read), .cmd_write(cmd_write),
    .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
    .resp_refused(resp_refused), .resp_rdata(resp_rdata),
    .vout_flag_set(ev[18:15]), .iout_flag_set(ev[14:11]),
    .vin_flag_set(ev[10:7]), .temp_event(ev[6]), .cml_event(ev[5]),
    .mfr_event(ev[4]), .fan_event(ev[3]), .other_event(ev[2]),
    .busy_event(ev[1]), .unknown_event(ev[0]), .clear_faults(clear),
    .power_stage_on(pso), .soft_start(s_start), .soft_stop(s_stop),
    .power_good(pgood));

  pss_host_model pss_host_model_i (
    .clock(clock), .cmd_code(cmd_code), .cmd_read(cmd_read),
    .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
    .resp_refused(resp_refused), .resp_rdata(resp_rdata));

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen,
        exp);
    end
  endtask

  task automatic in_range(input int v, lo, hi, input string what);
    check({15'h0000, v >= lo && v <= hi}, 16'h0001, what);
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic acc(input logic rd, input logic [7:0] code,
    input logic [15:0] d, exp, input logic r_exp);
    logic [15:0] q;
    logic r, ok;
    pss_host_model_i.xfer(rd, code, d, q, r, ok);
    if (!ok) begin
      n_errors++;
      $display("ERROR at %0t: no answer to code %h", $time, code);
      wrap_up();
    end
    check({15'h0000, r}, {15'h0000, r_exp}, "refusal flag");
    if (rd) check(q, exp, "read data");
  endtask

  task automatic wait_bit(input int idx, input logic lvl, output int k);
    k = 0;
    while (outs[idx] !== lvl) begin
      step(1);
      k++;
      if (k > 3000) begin
        n_errors++;
        $display("ERROR at %0t: output wait ran out", $time);
        wrap_up();
      end
    end
  endtask

  initial begin
    step(16);
    srst = 1'b0;
    step(2);
    for (i = 0; i < 5; i++) begin
      acc(1'b0, 8'h78 + 8'(i), 16'hffff, 16'h0000, 1'b1);
      acc(1'b1, 8'h78 + 8'(i), 16'h0000, ro_exp[i], 1'b0);
    end
    acc(1'b1, 8'h62, 16'h0000, 16'h0000, 1'b1);
    acc(1'b0, 8'h62, 16'h1234, 16'h0000, 1'b1);
    for (i = 0; i < 4; i++) begin
      acc(1'b1, t_code[i], 16'h0000, t_strap[i], 1'b0);
      acc(1'b0, t_code[i], t_new[i], 16'h0000, 1'b0);
      acc(1'b1, t_code[i], 16'h0000, t_new[i], 1'b0);
    end
    $display("Test registers done");
    for (i = 0; i < 15; i++) begin
      ev[ev_bit[i]] = 1'b1;
      step(1);
      ev = 19'h00000;
      acc(1'b1, 8'h79, 16'h0000, w_exp[i], 1'b0);
      acc(1'b1, 8'h78, 16'h0000, {8'h00, w_exp[i][7:0]}, 1'b0);
      acc(1'b1, d_code[i], 16'h0000, {8'h00, d_exp[i]}, 1'b0);
      clear = 1'b1;
      step(1);
      clear = 1'b0;
    end
    // A set in the same cycle as a clear must survive it
    ev = 19'h40002;
    clear = 1'b1;
    step(1);
    ev = 19'h00000;
    clear = 1'b0;
    acc(1'b1, 8'h79, 16'h0000, 16'h88e0, 1'b0);
    clear = 1'b1;
    step(1);
    clear = 1'b0;
    acc(1'b1, 8'h79, 16'h0000, 16'h0840, 1'b0);
    $display("Test status done");
    enable_pin = 1'b1;
    wait_bit(0, 1'b1, n);
    in_range(n, 2 * MS + 2, 2 * MS + 6, "on delay");
    wait_bit(1, 1'b0, n);
    in_range(n, 3 * MS - 1, 3 * MS + 2, "rise time");
    acc(1'b1, 8'h78, 16'h0000, 16'h0000, 1'b0);
    above = 1'b1;
    wait_bit(3, 1'b1, n);
    in_range(n, MS + 2, MS + 6, "power good rise");
    acc(1'b1, 8'h79, 16'h0000, 16'h0000, 1'b0);
    below = 1'b1;
    wait_bit(3, 1'b0, n);
    in_range(n, 1, 5, "power good fall");
    below = 1'b0;
    above = 1'b0;
    enable_pin = 1'b0;
    wait_bit(2, 1'b1, n);
    in_range(n, MS + 2, MS + 6, "off delay");
    wait_bit(2, 1'b0, n);
    in_range(n, 2 * MS - 1, 2 * MS + 2, "fall time");
    check({15'h0000, pso}, 16'h0000, "stage off");
    acc(1'b1, 8'h79, 16'h0000, 16'h0840, 1'b0);
    $display("Test sequencing done");
    wrap_up();
  end
endmodule
